/* File: inc/blocsr_pkg.sv */
// constants and types for the black-level offset register group
//
// Overview of operation
// - The one-byte status field reads 0x00 when unavailable, 0x01 when available and valid, 0x80 when a stored value is out of range.
// - The out-of-range code is shown whenever the group is available and the held value lies outside its present limits or holds a fraction.
// - Writing a four-byte float to relative position 0x0001 sets the offset as a percentage.
// - The float setting spans -100 to +100 in whole steps, possibly narrowed by related settings.
// - The read-only float at 0x0005 holds the lowest permitted setting, tracking the limits.
// - The read-only float at 0x0009 holds the highest permitted setting, tracking the limits.
// - Writing an integer to the two-byte field at 0x000D sets the offset directly.
// - The integer setting spans -100 to +100 in unit steps, possibly narrowed by related settings.
// - The integer offset is a sixteen-bit two's-complement quantity.
// - The first byte of the integer field is the low half and the second byte the high half.
// - Read-only fields at 0x000F and 0x0011 give the integer lower and upper limits, low byte first.
package blocsr_pkg;
    // printed offsets are not word multiples, so they are indices (byte address = 4 * index)
    localparam logic [4:0]  IDX_STATUS    = 5'h00;
    localparam logic [4:0]  IDX_PCT_SET   = 5'h01;
    localparam logic [4:0]  IDX_PCT_MIN   = 5'h05;
    localparam logic [4:0]  IDX_PCT_MAX   = 5'h09;
    localparam logic [4:0]  IDX_INT_SET   = 5'h0D;
    localparam logic [4:0]  IDX_INT_MIN   = 5'h0F;
    localparam logic [4:0]  IDX_INT_MAX   = 5'h11;
    localparam logic [4:0]  IDX_AVAIL     = 5'h14;
    localparam int          ADDR_W        = 7;
    // status codes
    localparam logic [7:0]  STAT_NONE     = 8'h00;
    localparam logic [7:0]  STAT_OK       = 8'h01;
    localparam logic [7:0]  STAT_RANGE    = 8'h80;
    // nominal range and reset values
    localparam logic [15:0] LVL_MIN_NOM   = 16'hFF9C;
    localparam logic [15:0] LVL_MAX_NOM   = 16'h0064;
    localparam logic [15:0] LVL_RESET     = 16'h0000;
    localparam logic        AVAIL_RESET   = 1'b1;
    // float layout
    localparam int          F_SIGN        = 31;
    localparam int          F_EXP_LSB     = 23;
    localparam logic [7:0]  F_BIAS        = 8'h7F;
    localparam logic [31:0] RD_UNMAPPED   = 32'h0000_0000;

    typedef enum logic [2:0] {
        BLOCSR_IDLE = 3'b001,
        BLOCSR_CONV = 3'b010,
        BLOCSR_DONE = 3'b100
    } blocsr_state_e;
endpackage

/* File: rtl/blocsr_f2i.sv */
`timescale 1ns/1ps
// single-precision float to 16-bit integer, truncating, saturating
module blocsr_f2i (
    input  wire logic [31:0] fval,
    output logic      [15:0] ival,
    output logic             frac
);
    import blocsr_pkg::*;
    logic [7:0]  ex;
    logic [23:0] man;
    logic [38:0] sh;
    logic [15:0] mag;
    // shift the mantissa by the unbiased exponent; anything >= 2^15 saturates
    always_comb begin
        ex   = fval[30:F_EXP_LSB];
        man  = {1'b1, fval[22:0]};
        sh   = '0;
        mag  = '0;
        frac = 1'b0;
        if (ex >= F_BIAS && ex < 8'h8E) begin
            sh   = {15'h0, man} << (ex - F_BIAS);
            mag  = {1'b0, sh[37:23]};
            frac = |sh[22:0];
        end else if (ex >= 8'h8E) begin
            mag = 16'h7FFF;
        end else if (ex != 8'h00) begin
            frac = 1'b1;
        end
        ival = fval[F_SIGN] ? 16'(-mag) : mag;
    end
endmodule

/* File: rtl/blocsr_i2f.sv */
`timescale 1ns/1ps
// 16-bit signed integer to single-precision float, exact
module blocsr_i2f (
    input  wire logic [15:0] ival,
    output logic      [31:0] fval
);
    import blocsr_pkg::*;
    logic [15:0] mag;
    logic [4:0]  msb;
    logic [15:0] norm;
    // any 16-bit integer fits the 24-bit mantissa, so no rounding
    always_comb begin
        mag  = ival[15] ? 16'(-ival) : ival;
        msb  = '0;
        for (int i = 0; i < 16; i++) begin
            if (mag[i]) begin
                msb = 5'(i);
            end
        end
        norm = mag << (5'd15 - msb);
        if (mag == 16'h0000) begin
            fval = 32'h0000_0000;
        end else begin
            fval = {ival[15], 8'(F_BIAS + {3'b000, msb}), norm[14:0], 8'h00};
        end
    end
endmodule

/* File: rtl/blocsr_top.sv */
`timescale 1ns/1ps
// black-level offset register group behind an avalon-mm slave
module blocsr_top (
    input  wire logic                          clock,
    input  wire logic                          rst,
    input  wire logic [blocsr_pkg::ADDR_W-1:0] avs_address,
    input  wire logic                          avs_read,
    input  wire logic                          avs_write,
    input  wire logic [31:0]                   avs_writedata,
    input  wire logic [3:0]                    avs_byteenable,
    output logic      [31:0]                   avs_readdata,
    output logic                               avs_waitrequest,
    input  wire logic [15:0]                   lim_lo,
    input  wire logic [15:0]                   lim_hi,
    output logic      [15:0]                   level
);
    import blocsr_pkg::*;

    typedef struct packed {
        blocsr_state_e st;
        logic [15:0]   lvl;
        logic          frac;
        logic          avail;
        logic [31:0]   rdata;
    } blocsr_s;

    blocsr_s q, d;
    logic [4:0]  idx;
    logic [15:0] lo_eff, hi_eff, f2i_val;
    logic        f2i_frac, out_rng;
    logic [31:0] lvl_f, lo_f, hi_f, wr_merged, rd_val;
    logic [7:0]  status;

    assign idx = avs_address[ADDR_W-1:2];

    // effective limits: nominal range narrowed by the related-settings inputs
    // nominal integer span
    always_comb begin
        lo_eff = ($signed(lim_lo) > $signed(LVL_MIN_NOM)) ? lim_lo : LVL_MIN_NOM;
        hi_eff = ($signed(lim_hi) < $signed(LVL_MAX_NOM)) ? lim_hi : LVL_MAX_NOM;
    end

    // converter sees the incoming write data so a float write lands in one step
    blocsr_f2i u_f2i (
        .fval (wr_merged),
        .ival (f2i_val),
        .frac (f2i_frac)
    );

    blocsr_i2f u_i2f_lvl (
        .ival (q.lvl),
        .fval (lvl_f)
    );
    blocsr_i2f u_i2f_lo (
        .ival (lo_eff),
        .fval (lo_f)
    );
    blocsr_i2f u_i2f_hi (
        .ival (hi_eff),
        .fval (hi_f)
    );

    // range check over the held value
    assign out_rng = q.frac
                  || $signed(q.lvl) < $signed(lo_eff)
                  || $signed(q.lvl) > $signed(hi_eff);

    always_comb begin
        if (!q.avail) begin
            status = STAT_NONE;
        end else if (out_rng) begin
            status = STAT_RANGE;
        end else begin
            status = STAT_OK;
        end
    end

    // byte-enable merge of write data over the current float view
    always_comb begin
        for (int b = 0; b < 4; b++) begin
            wr_merged[b*8 +: 8] = avs_byteenable[b] ? avs_writedata[b*8 +: 8] : lvl_f[b*8 +: 8];
        end
    end

    // read mux; unmapped indices read zero
    always_comb begin
        if (idx == IDX_STATUS) begin
            rd_val = {24'h000000, status};
        end else if (idx == IDX_PCT_SET) begin
            rd_val = lvl_f;
        end else if (idx == IDX_PCT_MIN) begin
            rd_val = lo_f;
        end else if (idx == IDX_PCT_MAX) begin
            rd_val = hi_f;
        end else if (idx == IDX_INT_SET) begin
            rd_val = {16'h0000, q.lvl};
        end else if (idx == IDX_INT_MIN) begin
            rd_val = {16'h0000, lo_eff};
        end else if (idx == IDX_INT_MAX) begin
            rd_val = {16'h0000, hi_eff};
        end else if (idx == IDX_AVAIL) begin
            rd_val = {31'h0, q.avail};
        end else begin
            rd_val = RD_UNMAPPED;
        end
    end

    // two wait cycles per access: request seen in IDLE, stored in CONV, answered in DONE
    always_comb begin
        d = q;
        case (q.st)
            BLOCSR_IDLE: begin
                if (avs_read || avs_write) begin
                    d.st = BLOCSR_CONV;
                end
            end
            BLOCSR_CONV: begin
                d.st    = BLOCSR_DONE;
                d.rdata = rd_val;
                if (avs_write) begin
                    if (idx == IDX_PCT_SET) begin
                        // whole steps; a fraction is kept as out of range
                        d.lvl  = f2i_val;
                        d.frac = f2i_frac;
                    end else if (idx == IDX_INT_SET) begin
                        // two's-complement, byte lanes 0 low 1 high
                        if (avs_byteenable[0]) begin
                            d.lvl[7:0] = avs_writedata[7:0];
                        end
                        if (avs_byteenable[1]) begin
                            d.lvl[15:8] = avs_writedata[15:8];
                        end
                        d.frac = 1'b0;
                    end else if (idx == IDX_AVAIL && avs_byteenable[0]) begin
                        d.avail = avs_writedata[0];
                    end
                end
            end
            BLOCSR_DONE: begin
                d.st = BLOCSR_IDLE;
            end
            default: begin
                d.st = BLOCSR_IDLE;
            end
        endcase
    end

    // state register, synchronous reset
    always_ff @(posedge clock) begin
        if (rst) begin
            q.st    <= BLOCSR_IDLE;
            q.lvl   <= LVL_RESET;
            q.frac  <= 1'b0;
            q.avail <= AVAIL_RESET;
            q.rdata <= 32'h0000_0000;
        end else begin
            q <= d;
        end
    end

    // waitrequest low during a request only in DONE, so the master holds for two edges
    assign avs_waitrequest = (avs_read || avs_write) && (q.st != BLOCSR_DONE);
    assign avs_readdata    = q.rdata;
    assign level           = q.lvl;

    status_zero_a: assert property (@(posedge clock) disable iff (rst)
        !q.avail |-> status == STAT_NONE)
        else $error("status not zero while unavailable");

    range_flag_a: assert property (@(posedge clock) disable iff (rst)
        (q.avail && ($signed(q.lvl) > $signed(hi_eff))) |-> status == STAT_RANGE)
        else $error("out-of-range level not flagged");

    status_ok_a: assert property (@(posedge clock) disable iff (rst)
        (q.avail && !q.frac && $signed(q.lvl) >= $signed(lo_eff)
         && $signed(q.lvl) <= $signed(hi_eff)) |-> status == STAT_OK)
        else $error("valid level not reported ok");

    // integer write lands two edges after request
    int_write_a: assert property (@(posedge clock) disable iff (rst)
        (q.st == BLOCSR_CONV && avs_write && idx == IDX_INT_SET && avs_byteenable[1:0] == 2'b11)
        |=> q.lvl == $past(avs_writedata[15:0]))
        else $error("integer write not stored");

    // float write of twenty gives level twenty
    float_write_a: assert property (@(posedge clock) disable iff (rst)
        (q.st == BLOCSR_CONV && avs_write && idx == IDX_PCT_SET
         && avs_byteenable == 4'hF && avs_writedata == 32'h41A0_0000)
        |=> q.lvl == 16'h0014)
        else $error("float write of 20 not stored");

    // float view tracks the shared level
    shared_view_a: assert property (@(posedge clock) disable iff (rst)
        (q.lvl == 16'hFFEC) |-> lvl_f == 32'hC1A0_0000)
        else $error("float view disagrees with level");

    limit_bound_a: assert property (@(posedge clock) disable iff (rst)
        $signed(lo_eff) >= $signed(LVL_MIN_NOM) && $signed(hi_eff) <= $signed(LVL_MAX_NOM))
        else $error("limit outside nominal range");

    // bus answer: request answered exactly on the third edge
    bus_answer_a: assert property (@(posedge clock) disable iff (rst)
        (q.st == BLOCSR_IDLE && (avs_read || avs_write)) |-> ##2 !avs_waitrequest)
        else $error("bus answer timing wrong");

    range_low_a: assert property (@(posedge clock) disable iff (rst)
        (q.avail && ($signed(q.lvl) < $signed(lo_eff))) |-> status == STAT_RANGE)
        else $error("below-range level not flagged");

    frac_flag_a: assert property (@(posedge clock) disable iff (rst)
        (q.avail && q.frac) |-> status == STAT_RANGE)
        else $error("fractional setting not flagged");

    // only the three documented codes appear
    status_code_a: assert property (@(posedge clock) disable iff (rst)
        status == STAT_NONE || status == STAT_OK || status == STAT_RANGE)
        else $error("status code outside the known set");

    // low-lane write keeps the high byte
    lo_byte_a: assert property (@(posedge clock) disable iff (rst)
        (q.st == BLOCSR_CONV && avs_write && idx == IDX_INT_SET && avs_byteenable[1:0] == 2'b01)
        |=> q.lvl == {$past(q.lvl[15:8]), $past(avs_writedata[7:0])})
        else $error("low byte write wrong");

    // high-lane write keeps the low byte
    hi_byte_a: assert property (@(posedge clock) disable iff (rst)
        (q.st == BLOCSR_CONV && avs_write && idx == IDX_INT_SET && avs_byteenable[1:0] == 2'b10)
        |=> q.lvl == {$past(avs_writedata[15:8]), $past(q.lvl[7:0])})
        else $error("high byte write wrong");

    // writes elsewhere leave the setting alone
    ro_write_a: assert property (@(posedge clock) disable iff (rst)
        (q.st == BLOCSR_CONV && avs_write && idx != IDX_PCT_SET && idx != IDX_INT_SET)
        |=> $stable(q.lvl))
        else $error("read-only write changed the level");

    avail_write_a: assert property (@(posedge clock) disable iff (rst)
        (q.st == BLOCSR_CONV && avs_write && idx == IDX_AVAIL && avs_byteenable[0])
        |=> q.avail == $past(avs_writedata[0]))
        else $error("availability write not stored");

    // sign bit gives a negative setting
    float_neg_a: assert property (@(posedge clock) disable iff (rst)
        (q.st == BLOCSR_CONV && avs_write && idx == IDX_PCT_SET
         && avs_byteenable == 4'hF && avs_writedata == 32'hC248_0000)
        |=> q.lvl == 16'hFFCE)
        else $error("float write of -50 not stored");

    // float minimum at nominal when not narrowed
    pct_min_read_a: assert property (@(posedge clock) disable iff (rst)
        (q.st == BLOCSR_CONV && avs_read && idx == IDX_PCT_MIN
         && $signed(lim_lo) <= $signed(LVL_MIN_NOM))
        |=> avs_readdata == 32'hC2C8_0000)
        else $error("float minimum not -100");

    // float maximum at nominal when not narrowed
    pct_max_read_a: assert property (@(posedge clock) disable iff (rst)
        (q.st == BLOCSR_CONV && avs_read && idx == IDX_PCT_MAX
         && $signed(lim_hi) >= $signed(LVL_MAX_NOM))
        |=> avs_readdata == 32'h42C8_0000)
        else $error("float maximum not +100");

    // integer minimum inside the nominal span
    int_min_read_a: assert property (@(posedge clock) disable iff (rst)
        (q.st == BLOCSR_CONV && avs_read && idx == IDX_INT_MIN)
        |=> $signed(avs_readdata[15:0]) >= $signed(LVL_MIN_NOM)
            && avs_readdata[31:16] == 16'h0000)
        else $error("integer minimum read wrong");

    // integer maximum inside the nominal span
    int_max_read_a: assert property (@(posedge clock) disable iff (rst)
        (q.st == BLOCSR_CONV && avs_read && idx == IDX_INT_MAX)
        |=> $signed(avs_readdata[15:0]) <= $signed(LVL_MAX_NOM)
            && avs_readdata[31:16] == 16'h0000)
        else $error("integer maximum read wrong");

    // integer field reads low byte first, upper lanes clear
    int_set_read_a: assert property (@(posedge clock) disable iff (rst)
        (q.st == BLOCSR_CONV && avs_read && idx == IDX_INT_SET)
        |=> avs_readdata == {16'h0000, $past(q.lvl)})
        else $error("integer setting read wrong");

    // zero setting reads as float zero
    pct_zero_a: assert property (@(posedge clock) disable iff (rst)
        (q.st == BLOCSR_CONV && avs_read && idx == IDX_PCT_SET
         && q.lvl == 16'h0000)
        |=> avs_readdata == 32'h0000_0000)
        else $error("zero setting not read as float zero");
endmodule

/* File: testbench/test_black_level_offset_csr.sv */
`timescale 1ns/1ps
// self-checking bench for the black-level offset register group
module test_black_level_offset_csr;
    import blocsr_pkg::*;
    localparam logic [31:0] M8  = 32'h0000_00FF;
    localparam logic [31:0] M16 = 32'h0000_FFFF;
    localparam logic [31:0] M32 = 32'hFFFF_FFFF;
    logic              clock          = 1'b0;
    logic              rst            = 1'b1;
    logic [ADDR_W-1:0] avs_address    = '0;
    logic              avs_read       = 1'b0;
    logic              avs_write      = 1'b0;
    logic [31:0]       avs_writedata  = '0;
    logic [3:0]        avs_byteenable = '0;
    logic [31:0]       avs_readdata;
    logic              avs_waitrequest;
    logic [15:0]       lim_lo         = LVL_MIN_NOM;
    logic [15:0]       lim_hi         = LVL_MAX_NOM;
    logic [15:0]       level;
    logic [31:0]       rdv;
    int                mismatches     = 0;
    int                tests_run      = 0;
    int                cycles         = 0;

    blocsr_top uut (.clock(clock), .rst(rst), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .lim_lo(lim_lo), .lim_hi(lim_hi),
        .level(level));

    // 25 mhz clock
    always #20 clock = ~clock;

    task summarize;
        $display("checks %0d mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // the whole run needs well under a thousand cycles
    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (cycles == 4000) begin
            mismatches = mismatches + 1;
            $display("BAD %0t timeout", $time);
            summarize();
        end
    end

    task chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        tests_run = tests_run + 1;
        if (got !== exp) begin
            mismatches = mismatches + 1;
            $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    // one bus cycle; request held until waitrequest is seen low at an edge
    task acc(input logic wr, input logic [4:0] idx, input logic [31:0] d,
             input logic [3:0] be);
        avs_address    <= {idx, 2'b00};
        avs_read       <= !wr;
        avs_write      <= wr;
        avs_writedata  <= d;
        avs_byteenable <= be;
        do @(posedge clock); while (avs_waitrequest !== 1'b0);
        rdv = avs_readdata;
        avs_read  <= 1'b0;
        avs_write <= 1'b0;
        @(posedge clock);
    endtask

    task wr(input logic [4:0] idx, input logic [31:0] d, input logic [3:0] be);
        acc(1'b1, idx, d, be);
    endtask

    task rd(input logic [4:0] idx, input logic [31:0] exp, input logic [31:0] m);
        acc(1'b0, idx, 32'h0000_0000, 4'hF);
        chk(rdv & m, exp, "read");
    endtask

    task lvl(input logic [15:0] exp);
        chk({16'h0000, level}, {16'h0000, exp}, "level");
    endtask

    initial begin
        repeat (2) @(posedge clock);
        rst <= 1'b0;
        @(posedge clock);
        // reset view and nominal limits
        rd(IDX_STATUS, 32'h01, M8);
        rd(IDX_PCT_SET, 32'h0, M32);
        rd(IDX_INT_SET, 32'h0, M16);
        rd(IDX_PCT_MIN, 32'hC2C8_0000, M32);
        rd(IDX_PCT_MAX, 32'h42C8_0000, M32);
        rd(IDX_INT_MIN, 32'hFF9C, M16);
        rd(IDX_INT_MAX, 32'h0064, M16);
        $display("test reset done");
        // integer writes and byte lanes
        wr(IDX_INT_SET, 32'h0000_FFEC, 4'h3);
        lvl(16'hFFEC);
        rd(IDX_PCT_SET, 32'hC1A0_0000, M32);
        wr(IDX_INT_SET, 32'h0000_0013, 4'h3);
        wr(IDX_INT_SET, 32'h0000_FF00, 4'h2);
        lvl(16'hFF13);
        rd(IDX_STATUS, 32'h80, M8);
        wr(IDX_INT_SET, 32'h0000_0000, 4'h2);
        rd(IDX_INT_SET, 32'h0013, M16);
        wr(IDX_INT_SET, 32'h0000_AB27, 4'h1);
        lvl(16'h0027);
        rd(IDX_STATUS, 32'h01, M8);
        $display("test integer done");
        // float writes
        wr(IDX_PCT_SET, 32'h41A0_0000, 4'hF);
        rd(IDX_INT_SET, 32'h0014, M16);
        wr(IDX_PCT_SET, 32'h4200_0000, 4'h8);
        lvl(16'h0050);
        wr(IDX_PCT_SET, 32'hC248_0000, 4'hF);
        lvl(16'hFFCE);
        wr(IDX_PCT_SET, 32'h4020_0000, 4'hF);
        rd(IDX_STATUS, 32'h80, M8);
        lvl(16'h0002);
        wr(IDX_PCT_SET, 32'h42C8_0000, 4'hF);
        rd(IDX_STATUS, 32'h01, M8);
        lvl(16'h0064);
        $display("test float done");
        // narrowed and over-wide limits
        lim_lo <= 16'hFFF6;
        lim_hi <= 16'h000A;
        rd(IDX_INT_MIN, 32'hFFF6, M16);
        rd(IDX_INT_MAX, 32'h000A, M16);
        rd(IDX_PCT_MIN, 32'hC120_0000, M32);
        rd(IDX_PCT_MAX, 32'h4120_0000, M32);
        rd(IDX_STATUS, 32'h80, M8);
        wr(IDX_INT_SET, 32'h0000_0005, 4'h3);
        rd(IDX_STATUS, 32'h01, M8);
        lim_lo <= 16'h8000;
        lim_hi <= 16'h7FFF;
        rd(IDX_INT_MIN, 32'hFF9C, M16);
        rd(IDX_INT_MAX, 32'h0064, M16);
        wr(IDX_INT_SET, 32'h0000_0065, 4'h3);
        rd(IDX_STATUS, 32'h80, M8);
        wr(IDX_INT_SET, 32'h0000_FF9C, 4'h3);
        rd(IDX_STATUS, 32'h01, M8);
        rd(IDX_PCT_SET, 32'hC2C8_0000, M32);
        $display("test limits done");
        // read-only and unmapped places
        wr(IDX_INT_MIN, 32'h0000_1234, 4'hF);
        rd(IDX_INT_MIN, 32'hFF9C, M16);
        wr(IDX_PCT_MAX, 32'h0000_0000, 4'hF);
        rd(IDX_PCT_MAX, 32'h42C8_0000, M32);
        rd(5'h1F, RD_UNMAPPED, M32);
        lvl(16'hFF9C);
        $display("test readonly done");
        // availability switch
        wr(IDX_AVAIL, 32'h0, 4'h1);
        rd(IDX_STATUS, 32'h00, M8);
        wr(IDX_AVAIL, 32'h1, 4'h1);
        rd(IDX_STATUS, 32'h01, M8);
        $display("test avail done");
        summarize();
    end
endmodule
